//--- sepr_eeprom_dev.sv
// EEPROM target end: 128-byte store, address pointer and read forms.
// Assumes the bus lines and chip select pins are asynchronous to sys_clk.
//
// Summary of operation
// - Pointer holds last accessed location plus one.
// - Read control byte: acknowledge, shift out byte.
// - Master nack then stop ends single read.
// - Random read: write control, address, repeated start.
// - Repeated start aborts write, keeps new address.
// - Master resends control byte with read direction.
// - After random read pointer is next location.
// - Master ack requests next consecutive byte.
// - Pointer increments by one after every data byte.
// - Pointer wraps from 7F to 00.
// - Acknowledge only matching type and chip selects.
// - No acknowledge while programming cycle runs.
// - On master nack release data line high.
`timescale 1ns/1ps
module sepr_eeprom_dev
   import sepr_pkg::*;
#(
   parameter int unsigned PROG_CYC = SEPR_PROG_CYC
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [2:0] chip_select_pins,
   sepr_if.dev bus,
   output logic prog_busy
);
   ////////////////////////////////////////////////////////////////////////////
   logic scl_s1;
   logic scl_s2;
   logic scl_d;
   logic sda_s1;
   logic sda_s2;
   logic sda_d;
   logic [2:0] cs_s1;
   logic [2:0] cs_s2;
   logic start_ev;
   logic stop_ev;
   logic rise;
   logic fall;
   sepr_dstate_t state;
   logic [3:0] bit_cnt;
   logic [7:0] rx;
   logic [7:0] tx;
   logic acked;
   logic ack_ok;
   logic [6:0] ptr;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_pend;
   logic mem_we;
   logic [14:0] busy_cnt;
   logic [7:0] mem [SEPR_MEM_DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers on the bus lines and chip select pins.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
         cs_s1 <= 3'h0;
         cs_s2 <= 3'h0;
      end
      else
      begin
         scl_s1 <= bus.scl;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
         cs_s1 <= chip_select_pins;
         cs_s2 <= cs_s1;
      end
   end

   assign start_ev = scl_s2 && scl_d && sda_d && !sda_s2;
   assign stop_ev = scl_s2 && scl_d && !sda_d && sda_s2;
   assign rise = scl_s2 && !scl_d;
   assign fall = !scl_s2 && scl_d;

   assign ack_ok = (state == SEPR_D_CTRL) ?
      (rx[7:4] == SEPR_TYPE_CODE && rx[3:1] == cs_s2 && !prog_busy) : !prog_busy;

   ////////////////////////////////////////////////////////////////////////////
   // Bus protocol, pointer and open-drain data driver.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state <= SEPR_D_IDLE;
         bit_cnt <= 4'h0;
         rx <= 8'h00;
         tx <= 8'h00;
         acked <= 1'b0;
         ptr <= SEPR_PTR_RST;
         wr_addr <= SEPR_PTR_RST;
         wr_data <= 8'h00;
         wr_pend <= 1'b0;
         bus.dev_sda_o <= 1'b0;
         bus.dev_sda_oe <= 1'b0;
      end
      else if (start_ev)
      begin
         state <= SEPR_D_CTRL;
         bit_cnt <= 4'h0;
         wr_pend <= 1'b0;
         bus.dev_sda_oe <= 1'b0;
      end
      else if (stop_ev)
      begin
         state <= SEPR_D_IDLE;
         bit_cnt <= 4'h0;
         wr_pend <= 1'b0;
         bus.dev_sda_oe <= 1'b0;
      end
      else
      begin
         case (state)
            SEPR_D_CTRL, SEPR_D_ADDR, SEPR_D_WDATA:
            begin
               if (rise && bit_cnt < SEPR_BIT_ACK)
               begin
                  rx <= {rx[6:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (rise && bit_cnt == SEPR_BIT_ACK)
               begin
                  bit_cnt <= SEPR_BIT_DONE;
               end
               else if (fall && bit_cnt == SEPR_BIT_ACK)
               begin
                  acked <= ack_ok;
                  bus.dev_sda_oe <= ack_ok;
               end
               else if (fall && bit_cnt == SEPR_BIT_DONE)
               begin
                  bit_cnt <= 4'h0;
                  bus.dev_sda_oe <= 1'b0;
                  if (!acked)
                  begin
                     state <= SEPR_D_IGN;
                  end
                  else if (state == SEPR_D_CTRL && rx[0])
                  begin
                     state <= SEPR_D_RDATA;
                     tx <= mem[ptr];
                     bus.dev_sda_oe <= !mem[ptr][7];
                  end
                  else if (state == SEPR_D_CTRL)
                  begin
                     state <= SEPR_D_ADDR;
                  end
                  else if (state == SEPR_D_ADDR)
                  begin
                     ptr <= rx[6:0];
                     state <= SEPR_D_WDATA;
                  end
                  else
                  begin
                     wr_data <= rx;
                     wr_addr <= ptr;
                     wr_pend <= 1'b1;
                     ptr <= ptr + SEPR_PTR_STEP;
                  end
               end
            end
            SEPR_D_RDATA:
            begin
               if (rise && bit_cnt < SEPR_BIT_ACK)
               begin
                  tx <= {tx[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (rise && bit_cnt == SEPR_BIT_ACK)
               begin
                  acked <= !sda_s2;
                  bit_cnt <= SEPR_BIT_DONE;
               end
               else if (fall && bit_cnt < SEPR_BIT_ACK)
               begin
                  bus.dev_sda_oe <= !tx[7];
               end
               else if (fall && bit_cnt == SEPR_BIT_ACK)
               begin
                  bus.dev_sda_oe <= 1'b0;
                  ptr <= ptr + SEPR_PTR_STEP;
               end
               else if (fall && bit_cnt == SEPR_BIT_DONE)
               begin
                  bit_cnt <= 4'h0;
                  if (acked)
                  begin
                     tx <= mem[ptr];
                     bus.dev_sda_oe <= !mem[ptr][7];
                  end
                  else
                  begin
                     state <= SEPR_D_IGN;
                     bus.dev_sda_oe <= 1'b0;
                  end
               end
            end
            default:
            begin
               bit_cnt <= 4'h0;
               bus.dev_sda_oe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory write on stop after a data byte, then a timed busy period.
   assign mem_we = stop_ev && wr_pend;

   always_ff @(posedge sys_clk)
   begin
      if (mem_we)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         busy_cnt <= 15'h0000;
         prog_busy <= 1'b0;
      end
      else if (mem_we)
      begin
         busy_cnt <= PROG_CYC[14:0];
         prog_busy <= 1'b1;
      end
      else if (busy_cnt > SEPR_PROG_CNT_ONE)
      begin
         busy_cnt <= busy_cnt - SEPR_PROG_CNT_ONE;
      end
      else
      begin
         busy_cnt <= 15'h0000;
         prog_busy <= 1'b0;
      end
   end
endmodule : sepr_eeprom_dev

//--- sepr_eeprom_mst.sv
// Two-wire bus master end: drives the serial clock and runs read commands.
// Assumes a user side on sys_clk and a target on the bus of sepr_if.
`timescale 1ns/1ps
module sepr_eeprom_mst
   import sepr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [2:0] cmd_cs,
   input wire logic [6:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] cmd_len,
   output logic cmd_ready,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic done,
   output logic nack_err,
   sepr_if.mst bus
);
   ////////////////////////////////////////////////////////////////////////////
   logic sda_s1;
   logic sda_s2;
   logic [3:0] div;
   logic qtick;
   logic [1:0] q;
   sepr_mstate_t state;
   sepr_stage_t stage;
   logic [1:0] op;
   logic [2:0] cs;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] left;
   logic [7:0] sh;
   logic [3:0] bit_cnt;
   logic rxing;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         div <= 4'h0;
      end
      else
      begin
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
         div <= (qtick || state == SEPR_M_IDLE) ? 4'h0 : div + 4'h1;
      end
   end

   assign qtick = (div == SEPR_QTR_CYC - 4'h1);

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer, one quarter of a serial clock period per tick.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state <= SEPR_M_IDLE;
         stage <= SEPR_ST_CTRLW;
         q <= 2'h0;
         op <= 2'h0;
         cs <= 3'h0;
         addr <= 7'h00;
         wdata <= 8'h00;
         left <= 8'h00;
         sh <= 8'h00;
         bit_cnt <= 4'h0;
         rxing <= 1'b0;
         cmd_ready <= 1'b1;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         done <= 1'b0;
         nack_err <= 1'b0;
         bus.mst_scl_o <= 1'b0;
         bus.mst_scl_oe <= 1'b0;
         bus.mst_sda_o <= 1'b0;
         bus.mst_sda_oe <= 1'b0;
      end
      else
      begin
         rd_valid <= 1'b0;
         done <= 1'b0;
         if (state != SEPR_M_IDLE && qtick)
         begin
            q <= q + 2'h1;
         end
         case (state)
            SEPR_M_IDLE:
            begin
               q <= 2'h0;
               if (cmd_valid)
               begin
                  op <= cmd_op;
                  cs <= cmd_cs;
                  addr <= cmd_addr;
                  wdata <= cmd_wdata;
                  left <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                  nack_err <= 1'b0;
                  cmd_ready <= 1'b0;
                  state <= SEPR_M_START;
               end
            end
            SEPR_M_START, SEPR_M_RSTART:
            begin
               if (qtick && q == 2'h0)
               begin
                  bus.mst_sda_oe <= 1'b0;
               end
               if (qtick && q == 2'h1)
               begin
                  bus.mst_scl_oe <= 1'b0;
               end
               if (qtick && q == 2'h2)
               begin
                  bus.mst_sda_oe <= 1'b1;
               end
               if (qtick && q == 2'h3)
               begin
                  bus.mst_scl_oe <= 1'b1;
                  bit_cnt <= 4'h0;
                  rxing <= 1'b0;
                  state <= SEPR_M_BYTE;
                  // Read control byte after repeated start, or after the first start for a current address read.
                  if (state == SEPR_M_RSTART || sepr_op_t'(op) == SEPR_OP_CUR)
                  begin
                     stage <= SEPR_ST_CTRLR;
                     sh <= {SEPR_TYPE_CODE, cs, 1'b1};
                  end
                  else
                  begin
                     stage <= SEPR_ST_CTRLW;
                     sh <= {SEPR_TYPE_CODE, cs, 1'b0};
                  end
               end
            end
            SEPR_M_BYTE:
            begin
               if (qtick && q == 2'h0)
               begin
                  if (bit_cnt == SEPR_BIT_ACK)
                  begin
                     bus.mst_sda_oe <= rxing && left != 8'h01;
                  end
                  else
                  begin
                     bus.mst_sda_oe <= !rxing && !sh[7];
                  end
               end
               if (qtick && q == 2'h1)
               begin
                  bus.mst_scl_oe <= 1'b0;
               end
               if (qtick && q == 2'h3)
               begin
                  bus.mst_scl_oe <= 1'b1;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt < SEPR_BIT_ACK)
                  begin
                     sh <= {sh[6:0], sda_s2};
                  end
                  else if (rxing)
                  begin
                     rd_data <= sh;
                     rd_valid <= 1'b1;
                     left <= left - 8'h01;
                     bit_cnt <= 4'h0;
                     if (left == 8'h01)
                     begin
                        state <= SEPR_M_STOP;
                     end
                  end
                  else if (sda_s2)
                  begin
                     nack_err <= 1'b1;
                     state <= SEPR_M_STOP;
                  end
                  else
                  begin
                     bit_cnt <= 4'h0;
                     case (stage)
                        SEPR_ST_CTRLW:
                        begin
                           stage <= SEPR_ST_ADDR;
                           sh <= {1'b0, addr};
                        end
                        SEPR_ST_ADDR:
                        begin
                           if (sepr_op_t'(op) == SEPR_OP_RAND)
                           begin
                              state <= SEPR_M_RSTART;
                           end
                           else
                           begin
                              stage <= SEPR_ST_WDATA;
                              sh <= wdata;
                           end
                        end
                        SEPR_ST_CTRLR:
                        begin
                           rxing <= 1'b1;
                        end
                        default:
                        begin
                           state <= SEPR_M_STOP;
                        end
                     endcase
                  end
               end
            end
            SEPR_M_STOP:
            begin
               if (qtick && q == 2'h0)
               begin
                  bus.mst_sda_oe <= 1'b1;
               end
               if (qtick && q == 2'h1)
               begin
                  bus.mst_scl_oe <= 1'b0;
               end
               if (qtick && q == 2'h2)
               begin
                  bus.mst_sda_oe <= 1'b0;
               end
               if (qtick && q == 2'h3)
               begin
                  done <= 1'b1;
                  cmd_ready <= 1'b1;
                  state <= SEPR_M_IDLE;
               end
            end
            default:
            begin
               state <= SEPR_M_IDLE;
            end
         endcase
      end
   end
endmodule : sepr_eeprom_mst

//--- sepr_if.sv
// Two-wire bus between the master end and the EEPROM end.
// Both lines are open drain with a pull-up; the wired level is resolved here.
`timescale 1ns/1ps
interface sepr_if;
   logic scl;
   logic sda;
   logic mst_scl_o;
   logic mst_scl_oe;
   logic mst_sda_o;
   logic mst_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   assign scl = !(mst_scl_oe && !mst_scl_o);
   assign sda = !((mst_sda_oe && !mst_sda_o) || (dev_sda_oe && !dev_sda_o));
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport mst (input scl, input sda, output mst_scl_o, output mst_scl_oe,
      output mst_sda_o, output mst_sda_oe);
endinterface : sepr_if

//--- sepr_monitor.sv
// Checker for the two-wire bus between the master end and the EEPROM end.
// Assumes plain bus levels and device pins, all seen on the sys_clk domain.
`timescale 1ns/1ps
module sepr_monitor
   import sepr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic [2:0] chip_select_pins,
   input wire logic prog_busy
);
   logic scl_q;
   logic sda_q;
   logic [7:0] sh;
   logic [3:0] bitn;
   logic first;
   logic rd;
   logic busy_seen;
   logic start_ev;
   logic stop_ev;
   logic rise;
   logic ack_rise;
   logic match;
   logic nack_ev;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   assign start_ev = scl_q && scl && sda_q && !sda;
   assign stop_ev = scl_q && scl && !sda_q && sda;
   assign rise = !scl_q && scl;
   assign ack_rise = rise && (bitn == 4'h8);
   assign match = (sh[7:4] == SEPR_TYPE_CODE) && (sh[3:1] == chip_select_pins);
   assign nack_ev = ack_rise && rd && !first && sda;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      scl_q <= rst ? 1'b1 : scl;
      sda_q <= rst ? 1'b1 : sda;
   end
   // Tracks bit position, first byte and read direction on the wire.
   always_ff @(posedge sys_clk)
   begin
      if (rst || start_ev)
      begin
         bitn <= 4'h0;
         first <= !rst;
         rd <= 1'b0;
         busy_seen <= prog_busy;
      end
      else
      begin
         busy_seen <= busy_seen || prog_busy;
         if (ack_rise)
         begin
            bitn <= 4'h0;
            first <= 1'b0;
            rd <= first ? (sh[0] && !sda) : rd;
         end
         else if (rise)
         begin
            sh <= {sh[6:0], sda};
            bitn <= bitn + 4'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // data moves low
   a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device data line changed while clock high");
   a_stop_quiet: assert property (stop_ev |=> !dev_sda_oe [*8])
      else $error("device drove data line after stop");
   a_start_quiet: assert property (start_ev |=> !dev_sda_oe [*8])
      else $error("device drove data line after start");
   a_nack_idle: assert property (nack_ev |=> !dev_sda_oe [*8])
      else $error("device drove data line after master nack");
   a_ctrl_ack: assert property (ack_rise && first && match && !busy_seen && !prog_busy
      |-> !sda)
      else $error("matching control byte not acknowledged");
   a_ctrl_refuse: assert property (ack_rise && first && !match |-> sda)
      else $error("foreign control byte acknowledged");
   a_busy_silent: assert property (ack_rise && prog_busy |-> sda)
      else $error("acknowledge given while programming");
   a_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("device drove data line high");
   a_ack_release: assert property (ack_rise && rd && !first |-> !dev_sda_oe)
      else $error("device held data line during master acknowledge");
   c_nack: cover property (nack_ev);
   c_busy: cover property (ack_rise && prog_busy);
   c_refuse: cover property (ack_rise && first && !match);
endmodule : sepr_monitor

//--- sepr_pkg.sv
// Constants and types shared by both ends of the serial EEPROM read path.
// Assumes a single system clock of 20 MHz on both ends.
package sepr_pkg;
   // Device type code in the control byte; the value is arbitrary.
   localparam logic [3:0] SEPR_TYPE_CODE = 4'h5;
   localparam int SEPR_ADDR_W = 7;
   localparam int SEPR_MEM_DEPTH = 128;
   localparam logic [6:0] SEPR_PTR_RST = 7'h00;
   localparam logic [6:0] SEPR_PTR_STEP = 7'h01;
   localparam logic [3:0] SEPR_BIT_ACK = 4'h8;
   localparam logic [3:0] SEPR_BIT_DONE = 4'h9;
   // Internal programming time and its count of system clocks.
   localparam int SEPR_CLK_MHZ = 20;
   localparam int SEPR_PROG_TIME_US = 1000;
   localparam int SEPR_PROG_CYC = SEPR_PROG_TIME_US * SEPR_CLK_MHZ;
   localparam logic [14:0] SEPR_PROG_CNT_ONE = 15'h0001;
   // System clocks per quarter of a serial clock period on the master.
   localparam logic [3:0] SEPR_QTR_CYC = 4'h5;
   typedef enum logic [2:0]
   {
      SEPR_D_IDLE = 3'h0,
      SEPR_D_CTRL = 3'h1,
      SEPR_D_ADDR = 3'h3,
      SEPR_D_WDATA = 3'h2,
      SEPR_D_RDATA = 3'h6,
      SEPR_D_IGN = 3'h7
   } sepr_dstate_t;
   typedef enum logic [2:0]
   {
      SEPR_M_IDLE = 3'h0,
      SEPR_M_START = 3'h1,
      SEPR_M_BYTE = 3'h3,
      SEPR_M_RSTART = 3'h2,
      SEPR_M_STOP = 3'h6
   } sepr_mstate_t;
   typedef enum logic [1:0]
   {
      SEPR_OP_CUR = 2'h0,
      SEPR_OP_RAND = 2'h1,
      SEPR_OP_WRITE = 2'h2
   } sepr_op_t;
   typedef enum logic [1:0]
   {
      SEPR_ST_CTRLW = 2'h0,
      SEPR_ST_ADDR = 2'h1,
      SEPR_ST_WDATA = 2'h3,
      SEPR_ST_CTRLR = 2'h2
   } sepr_stage_t;
endpackage : sepr_pkg

//--- test_serial_eeprom_read_path.sv
// Bench joining the master end to the EEPROM end over one bus.
// Assumes a model of memory and pointer kept in integers here.
`timescale 1ns/1ps
module test_serial_eeprom_read_path
   import sepr_pkg::*;
;
   localparam int PROG = 400;
   logic sys_clk;
   logic rst;
   logic [2:0] chip_select_pins;
   logic cmd_valid;
   logic [1:0] cmd_op;
   logic [2:0] cmd_cs;
   logic [6:0] cmd_addr;
   logic [7:0] cmd_wdata;
   logic [7:0] cmd_len;
   logic cmd_ready;
   logic [7:0] rd_data;
   logic rd_valid;
   logic done;
   logic nack_err;
   logic prog_busy;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int mem [SEPR_MEM_DEPTH];
   int ptr = 0;
   sepr_if bus ();
   sepr_eeprom_dev #(.PROG_CYC(PROG)) u_sepr_eeprom_dev (.sys_clk(sys_clk), .rst(rst),
      .chip_select_pins(chip_select_pins), .bus(bus), .prog_busy(prog_busy));
   sepr_eeprom_mst u_sepr_eeprom_mst (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_cs(cmd_cs), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_len(cmd_len), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .done(done), .nack_err(nack_err), .bus(bus));
   sepr_monitor u_sepr_monitor (.sys_clk(sys_clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
      .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
      .chip_select_pins(chip_select_pins), .prog_busy(prog_busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8
   task automatic chk1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   // Runs one command, updating the model first and comparing every byte.
   task automatic run(input logic [1:0] op, input logic [2:0] cs, input logic [6:0] a,
      input int len, input logic refuse);
      int k;
      int got;
      int exp_q [$];
      logic [7:0] wd;
      got = 0;
      wd = 8'($urandom);
      if (!refuse && op == SEPR_OP_WRITE)
      begin
         mem[a] = wd;
         ptr = (a + 1) % SEPR_MEM_DEPTH;
      end
      else if (!refuse)
      begin
         if (op == SEPR_OP_RAND)
            ptr = a;
         for (k = 0; k < len; k++)
         begin
            exp_q.push_back(mem[ptr]);
            ptr = (ptr + 1) % SEPR_MEM_DEPTH;
         end
      end
      @(negedge sys_clk);
      cmd_op = op;
      cmd_cs = cs;
      cmd_addr = a;
      cmd_wdata = wd;
      cmd_len = 8'(len);
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      chk1("ready while busy", 1'b0, cmd_ready);
      while (done !== 1'b1)
      begin
         if (rd_valid === 1'b1 && got < exp_q.size())
            chk8("read byte", 8'(exp_q[got]), rd_data);
         if (rd_valid === 1'b1)
            got++;
         @(negedge sys_clk);
      end
      chk8("byte count", 8'(exp_q.size()), 8'(got));
      chk1("refused", refuse, nack_err);
      chk1("ready after done", 1'b1, cmd_ready);
      if (op == SEPR_OP_WRITE)
         chk1("programming", 1'b1, prog_busy);
   endtask : run
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_errors++;
         summarize();
      end
   end
   initial
   begin
      logic [6:0] wa [5];
      void'($urandom(32'h800BAFE9));
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_cs = 3'h0;
      cmd_addr = 7'h00;
      cmd_wdata = 8'h00;
      cmd_len = 8'h00;
      chip_select_pins = 3'($urandom);
      wa = '{7'h7F, 7'h00, 7'h01, 7'h02, 7'(3 + ($urandom % 123))};
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      run(SEPR_OP_WRITE, chip_select_pins, 7'h7E, 1, 1'b0);
      run(SEPR_OP_CUR, chip_select_pins, 7'h00, 1, 1'b1);
      repeat (PROG) @(negedge sys_clk);
      for (int i = 0; i < 5; i++)
      begin
         run(SEPR_OP_WRITE, chip_select_pins, wa[i], 1, 1'b0);
         repeat (PROG) @(negedge sys_clk);
      end
      run(SEPR_OP_RAND, chip_select_pins, 7'h7E, 4, 1'b0);
      run(SEPR_OP_CUR, chip_select_pins, 7'h00, 1, 1'b0);
      run(SEPR_OP_RAND, chip_select_pins, wa[4], 1, 1'b0);
      run(SEPR_OP_RAND, chip_select_pins, 7'h7F, 2, 1'b0);
      for (int c = 0; c < 8; c++)
      begin
         if (3'(c) != chip_select_pins)
            run(SEPR_OP_RAND, 3'(c), 7'h02, 1, 1'b1);
      end
      run(SEPR_OP_CUR, chip_select_pins, 7'h00, 2, 1'b0);
      summarize();
   end
endmodule : test_serial_eeprom_read_path
